// *** rtl/awc_top.sv ***
// converter sequencing, burst control, limits and sticky flags
// How it works
// - each finished result is checked against both limits without software help.
// - upper and lower limits are held as high and low byte registers.
// - limits ordered normally, codes above the upper limit set the window flag.
// - codes below the lower limit set the window flag; equal codes do not.
// - lower above upper: only codes strictly between them set the flag.
// - upper above lower: codes outside the pair set the flag, others not.
// - the window flag is an output software can poll, not an interrupt.
// - the window flag stays set until software clears it.
// - in burst mode one trigger takes the selected number of samples, up to 64.
// - repeat count picks 1,4,8,16,32 or 64; result updates after the last.
// - power-up wait happens once per burst when the converter is off, then conversions run back to back.
// - done flag sets per conversion, or per burst in burst mode; software clears.
// - the temperature sensor is routed to the mux and floats while disabled.
`timescale 1ns/1ps
`default_nettype none
module awc_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_converter_on,
    input  wire logic        i_burst_mode_on,
    input  wire logic [2:0]  i_repeat_count_sel,
    input  wire logic        i_start_conv,
    input  wire logic [3:0]  i_limit_wr,
    input  wire logic [7:0]  i_limit_wdata,
    input  wire logic        i_window_clr,
    input  wire logic        i_done_clr,
    input  wire logic        i_temp_sensor_on,
    input  wire logic        i_mux_sel_temp,
    input  wire logic        i_core_done,
    input  wire logic [11:0] i_core_code,
    output logic             o_core_power_on,
    output logic             o_core_start,
    output logic             o_core_sel_temp,
    output logic             o_temp_sensor_en,
    output logic             o_temp_sensor_oe_n,
    output logic             o_busy,
    output logic [7:0]       o_result_high,
    output logic [7:0]       o_result_low,
    output logic [7:0]       o_upper_limit_high,
    output logic [7:0]       o_upper_limit_low,
    output logic [7:0]       o_lower_limit_high,
    output logic [7:0]       o_lower_limit_low,
    output logic             o_window_hit_flag,
    output logic             o_conversion_done_flag
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        awc_pkg::awc_state_e state;
        logic [7:0]          pwr_cnt;
        logic [6:0]          smp_cnt;
        logic [6:0]          target;
        logic [15:0]         upper;
        logic [15:0]         lower;
        logic                win_flag;
        logic                done_flag;
        logic                temp_on;
        logic                sel_temp;
    } awc_top_s;

    awc_top_s q;
    awc_top_s d;

    awc_res_if bus ();

    // ---------------------------------------------------------------
    // sub-blocks
    // ---------------------------------------------------------------
    awc_accum u_accum (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .bus       (bus.acc)
    );

    awc_window_cmp u_cmp (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .bus       (bus.cmp)
    );

    // ---------------------------------------------------------------
    // sample hand-off to the accumulator
    // ---------------------------------------------------------------
    logic last_smp;
    assign last_smp         = (q.smp_cnt == 7'(q.target - 7'h01));
    assign bus.sample_valid = (q.state == awc_pkg::AWC_WAIT) && i_core_done;
    assign bus.sample_code  = i_core_code;
    assign bus.sample_first = (q.smp_cnt == 7'h00);
    assign bus.sample_last  = last_smp;
    assign bus.upper        = q.upper;
    assign bus.lower        = q.lower;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.temp_on  = i_temp_sensor_on;
        d.sel_temp = i_mux_sel_temp;

        // limit byte writes
        if (i_limit_wr[awc_pkg::LIM_UH]) d.upper[15:8] = i_limit_wdata;
        if (i_limit_wr[awc_pkg::LIM_UL]) d.upper[7:0]  = i_limit_wdata;
        if (i_limit_wr[awc_pkg::LIM_LH]) d.lower[15:8] = i_limit_wdata;
        if (i_limit_wr[awc_pkg::LIM_LL]) d.lower[7:0]  = i_limit_wdata;

        // sticky flags: a new event wins over a clear in the same cycle
        d.win_flag  = (q.win_flag & ~i_window_clr) | (bus.result_valid & bus.hit);
        d.done_flag = (q.done_flag & ~i_done_clr) | bus.result_valid;

        case (q.state)
            awc_pkg::AWC_IDLE: begin
                if (i_start_conv && (i_converter_on || i_burst_mode_on)) begin
                    d.smp_cnt = 7'h00;
                    // single conversion when burst mode is off
                    d.target  = i_burst_mode_on ? awc_pkg::awc_rpt_count(i_repeat_count_sel) : 7'h01;
                    if (i_burst_mode_on && !i_converter_on) begin
                        d.pwr_cnt = 8'(awc_pkg::POWERUP_CYC - 1);
                        d.state   = awc_pkg::AWC_PWRUP;
                    end else begin
                        d.state   = awc_pkg::AWC_START;
                    end
                end
            end
            awc_pkg::AWC_PWRUP: begin
                if (q.pwr_cnt == 8'h00)
                    d.state = awc_pkg::AWC_START;
                else
                    d.pwr_cnt = 8'(q.pwr_cnt - 8'h01);
            end
            awc_pkg::AWC_START: begin
                d.state = awc_pkg::AWC_WAIT;
            end
            awc_pkg::AWC_WAIT: begin
                if (i_core_done) begin
                    d.smp_cnt = 7'(q.smp_cnt + 7'h01);
                    // next conversion starts at once, no second power-up
                    d.state = last_smp ? awc_pkg::AWC_FINISH : awc_pkg::AWC_START;
                end
            end
            awc_pkg::AWC_FINISH: begin
                d.state = awc_pkg::AWC_IDLE;
            end
            default: begin
                d.state = awc_pkg::AWC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q          <= '0;
            q.state    <= awc_pkg::AWC_IDLE;
            q.upper    <= awc_pkg::UPPER_RST;
            q.lower    <= awc_pkg::LOWER_RST;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // converter stays powered for the whole burst
    assign o_core_power_on        = i_converter_on || (q.state != awc_pkg::AWC_IDLE);
    assign o_core_start           = (q.state == awc_pkg::AWC_START);
    assign o_core_sel_temp        = q.sel_temp;
    assign o_temp_sensor_en       = q.temp_on;
    assign o_temp_sensor_oe_n     = ~q.temp_on;
    assign o_busy                 = (q.state != awc_pkg::AWC_IDLE);
    assign o_result_high          = bus.result[15:8];
    assign o_result_low           = bus.result[7:0];
    assign o_upper_limit_high     = q.upper[15:8];
    assign o_upper_limit_low      = q.upper[7:0];
    assign o_lower_limit_high     = q.lower[15:8];
    assign o_lower_limit_low      = q.lower[7:0];
    assign o_window_hit_flag      = q.win_flag;
    assign o_conversion_done_flag = q.done_flag;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    window_set_a: assert property (
        (bus.result_valid && bus.hit) |=> o_window_hit_flag)
        else $error("window hit did not set the flag");

    window_sticky_a: assert property (
        (o_window_hit_flag && !i_window_clr) |=> o_window_hit_flag)
        else $error("window flag dropped without a clear");

    window_cause_a: assert property (
        $rose(o_window_hit_flag) |-> $past(bus.result_valid && bus.hit))
        else $error("window flag rose without a hit");

    limit_write_a: assert property (
        i_limit_wr[awc_pkg::LIM_LL] |=> (o_lower_limit_low == $past(i_limit_wdata)))
        else $error("lower limit low byte not written");

    done_after_series_a: assert property (
        $rose(o_conversion_done_flag) |-> $past(q.state == awc_pkg::AWC_FINISH))
        else $error("done flag set before the series ended");

    burst_count_a: assert property (
        (q.state == awc_pkg::AWC_FINISH) |-> (q.smp_cnt == q.target))
        else $error("burst ended with wrong sample count");

    single_no_burst_a: assert property (
        (q.state == awc_pkg::AWC_IDLE && i_start_conv && i_converter_on && !i_burst_mode_on)
        |=> (q.target == 7'h01))
        else $error("non-burst trigger did not select one sample");

    powerup_len_a: assert property (
        $rose(q.state == awc_pkg::AWC_PWRUP) |-> (q.pwr_cnt == 8'(awc_pkg::POWERUP_CYC - 1)))
        else $error("power-up interval loaded wrongly");

    back_to_back_a: assert property (
        (q.state == awc_pkg::AWC_WAIT && i_core_done && !last_smp) |=> o_core_start ##1 !o_core_start)
        else $error("next conversion not started at once");

    temp_float_a: assert property (
        !i_temp_sensor_on |=> o_temp_sensor_oe_n)
        else $error("temperature sensor driven while disabled");

    // ---------------------------------------------------------------
    // sequencing, result and flag clearing
    // ---------------------------------------------------------------
    start_one_cycle_a: assert property (
        o_core_start |=> !o_core_start)
        else $error("start pulse longer than one cycle");

    no_second_powerup_a: assert property (
        (q.state == awc_pkg::AWC_WAIT) |=> (q.state != awc_pkg::AWC_PWRUP))
        else $error("power-up repeated inside a burst");

    powerup_end_a: assert property (
        (q.state == awc_pkg::AWC_PWRUP && q.pwr_cnt == 8'h00) |=> o_core_start)
        else $error("conversion not started after power-up");

    trigger_refused_a: assert property (
        (!o_busy && !(i_start_conv && (i_converter_on || i_burst_mode_on))) |=> !o_busy)
        else $error("busy without an accepted trigger");

    burst64_target_a: assert property (
        (!o_busy && i_start_conv && i_burst_mode_on && i_repeat_count_sel == awc_pkg::RPT_64)
        |=> (q.target == 7'h40))
        else $error("repeat select did not give 64 samples");

    result_after_last_a: assert property (
        (q.state == awc_pkg::AWC_WAIT && i_core_done && last_smp) |=> bus.result_valid)
        else $error("result not updated after the last conversion");

    result_hold_a: assert property (
        !bus.result_valid |-> $stable({o_result_high, o_result_low}))
        else $error("result changed between series");

    done_set_a: assert property (
        bus.result_valid |=> o_conversion_done_flag)
        else $error("done flag not set after a result");

    done_clear_a: assert property (
        (o_conversion_done_flag && i_done_clr && !bus.result_valid) |=> !o_conversion_done_flag)
        else $error("done flag not cleared");

    window_clear_a: assert property (
        (o_window_hit_flag && i_window_clr && !(bus.result_valid && bus.hit)) |=> !o_window_hit_flag)
        else $error("window flag not cleared");

    upper_write_a: assert property (
        i_limit_wr[awc_pkg::LIM_UH] |=> (o_upper_limit_high == $past(i_limit_wdata)))
        else $error("upper limit high byte not written");

    limit_hold_a: assert property (
        (i_limit_wr == 4'h0) |=> $stable({q.upper, q.lower}))
        else $error("limit changed without a write");

    temp_route_a: assert property (
        i_mux_sel_temp |=> o_core_sel_temp)
        else $error("sensor channel not routed to the mux");

    burst64_c: cover property (
        (q.state == awc_pkg::AWC_FINISH) && (q.target == 7'h40));
    window_hit_c: cover property (
        bus.result_valid && bus.hit);
    powerup_c: cover property (
        (q.state == awc_pkg::AWC_PWRUP) ##1 (q.state == awc_pkg::AWC_START));
    set_clear_c: cover property (
        bus.result_valid && i_done_clr);
    refused_trigger_c: cover property (
        !o_busy && i_start_conv && !i_converter_on && !i_burst_mode_on);

endmodule : awc_top
`default_nettype wire

// *** rtl/awc_pkg.sv ***
// constants, state codes and shared functions of the window compare and burst block
package awc_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int CODE_W    = 12;
    localparam int RES_W     = 16;
    localparam int PWR_CNT_W = 8;
    localparam int SMP_CNT_W = 7;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int POWERUP_NS    = 1000;
    // least time, so round up to whole cycles
    localparam int POWERUP_CYC   = (POWERUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ---------------------------------------------------------------
    // reset values and limit write strobe positions
    // ---------------------------------------------------------------
    localparam logic [15:0] UPPER_RST = 16'hFFFF;
    localparam logic [15:0] LOWER_RST = 16'h0000;
    localparam int LIM_UH = 0;
    localparam int LIM_UL = 1;
    localparam int LIM_LH = 2;
    localparam int LIM_LL = 3;

    // ---------------------------------------------------------------
    // repeat count encodings
    // ---------------------------------------------------------------
    localparam logic [2:0] RPT_1  = 3'h0;
    localparam logic [2:0] RPT_4  = 3'h1;
    localparam logic [2:0] RPT_8  = 3'h2;
    localparam logic [2:0] RPT_16 = 3'h3;
    localparam logic [2:0] RPT_32 = 3'h4;
    localparam logic [2:0] RPT_64 = 3'h5;

    typedef enum logic [4:0] {
        AWC_IDLE   = 5'h01,
        AWC_PWRUP  = 5'h02,
        AWC_START  = 5'h04,
        AWC_WAIT   = 5'h08,
        AWC_FINISH = 5'h10
    } awc_state_e;

    // samples per burst; reserved codes fall back to one sample
    function automatic logic [SMP_CNT_W-1:0] awc_rpt_count(input logic [2:0] sel);
        case (sel)
            RPT_4:   return 7'h04;
            RPT_8:   return 7'h08;
            RPT_16:  return 7'h10;
            RPT_32:  return 7'h20;
            RPT_64:  return 7'h40;
            default: return 7'h01;
        endcase
    endfunction : awc_rpt_count

    // unsigned 16-bit window test
    function automatic logic awc_window_hit(input logic [15:0] code,
                                            input logic [15:0] upper,
                                            input logic [15:0] lower);
        if (lower <= upper)
            return (code > upper) || (code < lower);
        else
            return (code > upper) && (code < lower);
    endfunction : awc_window_hit

endpackage : awc_pkg

// *** rtl/awc_res_if.sv ***
// signals joining the controller, the accumulator and the window comparator
`timescale 1ns/1ps
`default_nettype none
interface awc_res_if;
    logic        sample_valid;
    logic [11:0] sample_code;
    logic        sample_first;
    logic        sample_last;
    logic        result_valid;
    logic [15:0] result;
    logic [15:0] upper;
    logic [15:0] lower;
    logic        hit;

    modport ctl (output sample_valid, sample_code, sample_first, sample_last, upper, lower,
                 input  result_valid, result, hit);
    modport acc (input  sample_valid, sample_code, sample_first, sample_last,
                 output result_valid, result);
    modport cmp (input  result, upper, lower,
                 output hit);
endinterface : awc_res_if
`default_nettype wire

// *** rtl/awc_accum.sv ***
// burst accumulator and result register
`timescale 1ns/1ps
`default_nettype none
module awc_accum (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    awc_res_if.acc    bus
);
    typedef struct packed {
        logic [15:0] sum;
        logic [15:0] result;
        logic        valid;
    } awc_acc_s;

    awc_acc_s q;
    awc_acc_s d;

    always_comb begin
        logic [15:0] nxt;
        nxt = 16'h0000;
        d = q;
        d.valid = 1'b0;
        if (bus.sample_valid) begin
            nxt = bus.sample_first ? 16'(bus.sample_code) : 16'(q.sum + 16'(bus.sample_code));
            d.sum = nxt;
            if (bus.sample_last) begin
                d.result = nxt;
                d.valid  = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign bus.result       = q.result;
    assign bus.result_valid = q.valid;

    result_on_last_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (q.result != $past(q.result)) |-> q.valid)
        else $error("result changed without a finished series");

endmodule : awc_accum
`default_nettype wire

// *** rtl/awc_window_cmp.sv ***
// window comparator on the result register
`timescale 1ns/1ps
`default_nettype none
module awc_window_cmp (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    awc_res_if.cmp    bus
);
    assign bus.hit = awc_pkg::awc_window_hit(bus.result, bus.upper, bus.lower);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    above_upper_a: assert property (
        (bus.lower <= bus.upper && bus.result > bus.upper) |-> bus.hit)
        else $error("code above upper limit not flagged");
    below_lower_a: assert property (
        (bus.result < bus.lower && bus.lower <= bus.upper) |-> bus.hit)
        else $error("code below lower limit not flagged");
    inside_window_a: assert property (
        (bus.lower > bus.upper) |-> (bus.hit == (bus.result > bus.upper && bus.result < bus.lower)))
        else $error("inside window test wrong");
    outside_equal_a: assert property (
        (bus.lower <= bus.upper && bus.result >= bus.lower && bus.result <= bus.upper) |-> !bus.hit)
        else $error("code on or between limits flagged");

endmodule : awc_window_cmp
`default_nettype wire

// *** bench/awc_core_model.sv ***
// behavioural converter core answering start pulses with a code
`timescale 1ns/1ps
`default_nettype none
module awc_core_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_power_on,
    input  wire logic        i_start,
    input  wire logic [11:0] i_code,
    input  wire logic [3:0]  i_delay,
    output logic             o_done,
    output logic [11:0]      o_code
);
    logic [3:0] cnt_q;
    logic       busy_q;

    // code bus is not held outside the done pulse, so it toggles every cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q  <= 4'h0;
            busy_q <= 1'b0;
            o_done <= 1'b0;
            o_code <= 12'h000;
        end else begin
            o_done <= 1'b0;
            o_code <= ~o_code;
            if (i_start && i_power_on) begin
                busy_q <= 1'b1;
                cnt_q  <= i_delay;
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    o_done <= 1'b1;
                    o_code <= i_code;
                    busy_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end
endmodule : awc_core_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench of the window compare and burst block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0, rst_n = 1'b0, con = 1'b0, bm = 1'b0, start = 1'b0;
    logic [2:0]  rsel = 3'h0;
    logic [3:0]  lwr = 4'h0, dly = 4'h0;
    logic [7:0]  lwd = 8'h00, rh, rl, uh, ul, lh, ll;
    logic        wclr = 1'b0, dclr = 1'b0, ton = 1'b0, msel = 1'b0;
    logic        cdone, pwr, cstart, csel, ten, toe_n, busy, wflag, dflag;
    logic [11:0] ccode, ncode = 12'h000;
    int          miscompares = 0, tests_run = 0, cycles = 0;
    logic [15:0] up[15] = '{16'h0080, 16'h0080, 16'h0080, 16'h0080, 16'h03FF, 16'h03FF, 16'h0040, 16'h0040,
                            16'h0040, 16'h0040, 16'h0080, 16'h0080, 16'h0080, 16'h0080, 16'h0080};
    logic [15:0] lo[15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h0040, 16'h0080, 16'h0080,
                            16'h0080, 16'h0080, 16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0040};
    logic [11:0] cd[15] = '{12'h081, 12'h080, 12'h07F, 12'hFFF, 12'h03F, 12'h040, 12'h041, 12'h07F,
                            12'h080, 12'h040, 12'h081, 12'h03F, 12'h060, 12'h040, 12'h080};
    logic        hit[15] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    initial begin
        forever #4 clk = ~clk;
    end

    awc_top dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_converter_on(con), .i_burst_mode_on(bm),
        .i_repeat_count_sel(rsel), .i_start_conv(start), .i_limit_wr(lwr), .i_limit_wdata(lwd),
        .i_window_clr(wclr), .i_done_clr(dclr), .i_temp_sensor_on(ton), .i_mux_sel_temp(msel),
        .i_core_done(cdone), .i_core_code(ccode), .o_core_power_on(pwr), .o_core_start(cstart),
        .o_core_sel_temp(csel), .o_temp_sensor_en(ten), .o_temp_sensor_oe_n(toe_n), .o_busy(busy),
        .o_result_high(rh), .o_result_low(rl), .o_upper_limit_high(uh), .o_upper_limit_low(ul),
        .o_lower_limit_high(lh), .o_lower_limit_low(ll), .o_window_hit_flag(wflag),
        .o_conversion_done_flag(dflag));

    awc_core_model core (.i_clk_sys(clk), .i_rst_n(rst_n), .i_power_on(pwr), .i_start(cstart),
        .i_code(ncode), .i_delay(dly), .o_done(cdone), .o_code(ccode));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrlim(input logic [15:0] u, input logic [15:0] l);
        logic [7:0] b[4];
        b = '{u[15:8], u[7:0], l[15:8], l[7:0]};
        for (int i = 0; i < 4; i++) begin
            lwr = 4'(1 << i);
            lwd = b[i];
            @(negedge clk);
        end
        lwr = 4'h0;
        @(negedge clk);
        chk({uh, ul}, u);
        chk({lh, ll}, l);
    endtask : wrlim

    task automatic clr();
        wclr = 1'b1;
        dclr = 1'b1;
        @(negedge clk);
        wclr = 1'b0;
        dclr = 1'b0;
        @(negedge clk);
    endtask : clr

    // one trigger; counts start pulses, power drops and early result changes
    task automatic conv(input logic on, input logic b, input logic [2:0] sel, input logic [11:0] code,
                        input int n, input int lat);
        int k, first, starts, drops, early;
        logic [15:0] old;
        old = {rh, rl};
        k = 0;
        first = -1;
        starts = 0;
        drops = 0;
        early = 0;
        con = on;
        bm = b;
        rsel = sel;
        ncode = code;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while (busy === 1'b1 && k < 2000) begin
            if (cstart === 1'b1) begin
                if (first < 0)
                    first = k;
                starts++;
            end
            if (pwr !== 1'b1)
                drops++;
            if (starts < n && {rh, rl} !== old)
                early++;
            k++;
            @(negedge clk);
        end
        @(negedge clk);
        chk(16'(first), 16'(lat));
        chk(16'(starts), 16'(n));
        chk(16'(drops), 16'h0000);
        chk(16'(early), 16'h0000);
        chk({rh, rl}, (n > 0) ? 16'(n * code) : old);
        chk({15'h0000, dflag}, (n > 0) ? 16'h0001 : 16'h0000);
    endtask : conv

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({wflag, dflag, busy, toe_n}, 16'h0001);
        chk({uh, ul}, 16'hFFFF);
        chk({lh, ll}, 16'h0000);
        chk({rh, rl}, 16'h0000);
    endtask : t_reset

    task automatic t_window();
        for (int i = 0; i < 15; i++) begin
            wrlim(up[i], lo[i]);
            clr();
            conv(1'b1, 1'b0, 3'h5, cd[i], 1, 0);
            chk({15'h0000, wflag}, {15'h0000, hit[i]});
        end
    endtask : t_window

    task automatic t_sticky();
        wrlim(16'h0080, 16'h0000);
        clr();
        conv(1'b1, 1'b0, 3'h0, 12'h081, 1, 0);
        conv(1'b1, 1'b0, 3'h0, 12'h010, 1, 0);
        chk({15'h0000, wflag}, 16'h0001);
        clr();
        chk({wflag, dflag}, 16'h0000);
    endtask : t_sticky

    task automatic t_burst();
        for (int s = 0; s < 8; s++) begin
            dly = s[0] ? 4'h3 : 4'h0;
            clr();
            conv(1'b0, 1'b1, 3'(s), 12'hFFF, (s == 0 || s > 5) ? 1 : (2 << s), awc_pkg::POWERUP_CYC);
        end
        conv(1'b1, 1'b1, awc_pkg::RPT_4, 12'h123, 4, 0);
        clr();
        conv(1'b0, 1'b0, 3'h0, 12'h456, 0, -1);
    endtask : t_burst

    task automatic t_temp();
        ton = 1'b1;
        msel = 1'b1;
        @(negedge clk);
        chk({ten, toe_n, csel}, 16'h0005);
        ton = 1'b0;
        msel = 1'b0;
        @(negedge clk);
        chk({ten, toe_n, csel}, 16'h0002);
    endtask : t_temp

    task automatic t_midreset();
        wrlim(16'h0100, 16'h0010);
        con = 1'b0;
        bm = 1'b1;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk({busy, wflag, dflag, pwr}, 16'h0000);
        chk({uh, ul}, 16'hFFFF);
        rst_n = 1'b1;
        @(negedge clk);
    endtask : t_midreset

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_window();
        t_sticky();
        t_burst();
        t_temp();
        t_midreset();
        end_sim();
    end
endmodule : tb
`default_nettype wire
